// *** logic/pau_top.sv ***
/*
 * Process alarm unit: four alarms with timing and initial blocking, output
 * ownership, soft-start, on/off control, remote setpoint, square-root input
 * and retransmission scaling, with a small register port.
 * Assumes PV, setpoint, loop output and program state come from logic on
 * CLK_I; sensor flags and the remote-select contact come from pins.
 */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pau_consts.svh"

module pau_top #(
    parameter int SEC_CYCLES = `PAU_SEC_CYCLES
) (
    input  wire logic                 CLK_I,
    input  wire logic                 RESET_I,
    input  wire logic [7:0]           ADDR_I,
    input  wire logic [15:0]          WDATA_I,
    input  wire logic                 WR_I,
    input  wire logic                 RD_I,
    output logic      [15:0]          RDATA_O,
    input  wire pau_pkg::pau_pins_s   PINS_I,
    input  wire pau_pkg::pau_program_s PROGRAM_I,
    input  wire logic signed [15:0]   PV_I,
    input  wire logic [15:0]          CURRENT_I,
    input  wire logic signed [15:0]   REMOTE_SP_I,
    input  wire logic [9:0]           PID_I,
    output logic      [3:0]           ALARM_OUT_O,
    output logic      [3:0]           ALARM_LED_O,
    output logic      [9:0]           CTRL_OUT_O,
    output logic signed [15:0]        SETPOINT_O,
    output logic      [11:0]          RETX_O
);
    import pau_pkg::*;

    localparam int NA = `PAU_NUM_ALARMS;
    localparam int TW = `PAU_TIME_W;

    // =====================================================================
    // Registers written by software
    // =====================================================================
    logic [15:0]        ctrl_reg;
    logic [9:0]         mv_reg;
    logic [15:0]        pb_reg;
    logic [TW-1:0]      soft_reg;
    logic signed [15:0] rtx_lo_reg;
    logic signed [15:0] rtx_hi_reg;
    logic signed [15:0] main_sp_reg;
    pau_func_e          func_reg [NA];
    logic [5:0]         seg_reg  [NA];
    logic signed [15:0] thr_reg  [NA];
    logic [TW-1:0]      t1_reg   [NA];
    logic [TW-1:0]      t2_reg   [NA];

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl_reg    <= `PAU_CTRL_RESET;
            mv_reg      <= '0;
            pb_reg      <= '0;
            soft_reg    <= '0;
            rtx_lo_reg  <= '0;
            rtx_hi_reg  <= '0;
            main_sp_reg <= '0;
            for (int n = 0; n < NA; n++) begin
                func_reg[n] <= PAU_FN_OFF;
                seg_reg[n]  <= '0;
                thr_reg[n]  <= '0;
                t1_reg[n]   <= '0;
                t2_reg[n]   <= '0;
            end
        end else if (WR_I) begin
            case (ADDR_I)
                `PAU_A_CTRL:    ctrl_reg    <= WDATA_I;
                `PAU_A_MV:      mv_reg      <= WDATA_I[9:0];
                `PAU_A_PB:      pb_reg      <= WDATA_I;
                `PAU_A_SOFT:    soft_reg    <= WDATA_I[TW-1:0];
                `PAU_A_RTX_LO:  rtx_lo_reg  <= WDATA_I;
                `PAU_A_RTX_HI:  rtx_hi_reg  <= WDATA_I;
                `PAU_A_MAIN_SP: main_sp_reg <= WDATA_I;
                default: begin
                end
            endcase
            for (int n = 0; n < NA; n++) begin
                if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_FUNC)) begin
                    func_reg[n] <= pau_func_e'(WDATA_I[2:0]);
                    seg_reg[n]  <= WDATA_I[13:8];
                end
                if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_THR)) begin
                    thr_reg[n] <= WDATA_I;
                end
                if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_T1)) begin
                    t1_reg[n] <= WDATA_I[TW-1:0];
                end
                if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_T2)) begin
                    t2_reg[n] <= WDATA_I[TW-1:0];
                end
            end
        end
    end

    // =====================================================================
    // Pin synchroniser: a change is taken once stages two and three agree
    // =====================================================================
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    pau_pins_s  pins_reg;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pins_reg   <= '0;
        end else begin
            pin_s1_reg <= PINS_I;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pins_reg   <= (pin_s2_reg & pin_s3_reg) | (pins_reg & (pin_s2_reg | pin_s3_reg));
        end
    end

    // =====================================================================
    // One-second time base
    // =====================================================================
    logic [31:0] sec_cnt_reg;
    logic        sec_tick;

    assign sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));

    always_ff @(posedge CLK_I) begin
        if (RESET_I || sec_tick) begin
            sec_cnt_reg <= '0;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
        end
    end

    // =====================================================================
    // Square root of the normalised loop current, one bit per cycle
    // =====================================================================
    logic [27:0] rad_reg;
    logic [13:0] root_reg;
    logic [13:0] sqrt_reg;
    logic [3:0]  sq_idx_reg;
    logic [15:0] cur_norm;
    logic [13:0] root_try;

    // Below 4 mA reads as zero and above 20 mA as full scale.
    assign cur_norm = (CURRENT_I <= `PAU_CUR_ZERO) ? 16'h0000 :
                      (CURRENT_I >= `PAU_CUR_ZERO + `PAU_CUR_SPAN) ? `PAU_CUR_SPAN :
                      16'(CURRENT_I - `PAU_CUR_ZERO);
    assign root_try = root_reg | (14'h0001 << sq_idx_reg);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rad_reg    <= '0;
            root_reg   <= '0;
            sqrt_reg   <= '0;
            sq_idx_reg <= 4'hD;
        end else if (sq_idx_reg == 4'hF) begin
            sqrt_reg   <= root_reg;
            root_reg   <= '0;
            rad_reg    <= 28'(cur_norm * `PAU_CUR_SPAN);
            sq_idx_reg <= 4'hD;
        end else begin
            if (28'(root_try * root_try) <= rad_reg) begin
                root_reg <= root_try;
            end
            sq_idx_reg <= sq_idx_reg - 4'h1;
        end
    end

    logic signed [15:0] pv;
    assign pv = ctrl_reg[`PAU_CTRL_SQRT] ? $signed({2'b00, sqrt_reg}) : PV_I;

    // =====================================================================
    // Setpoint source
    // =====================================================================
    logic signed [15:0] sp;
    assign sp = (pins_reg.remote_select || ctrl_reg[`PAU_CTRL_RSP_EN]) ?
                REMOTE_SP_I : main_sp_reg;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            SETPOINT_O <= '0;
        end else begin
            SETPOINT_O <= sp;
        end
    end

    // =====================================================================
    // Alarms
    // =====================================================================
    logic [NA-1:0] led;
    logic [NA-1:0] aout;

    for (genvar g = 0; g < NA; g++) begin : g_alarm
        logic signed [17:0] lo_b;
        logic signed [17:0] hi_b;
        logic signed [17:0] pv_x;
        logic               cond;
        logic               blocked_reg;
        logic               rec;
        pau_tstate_e        st_reg;
        logic [TW-1:0]      cnt_reg;
        logic               last;

        assign pv_x = 18'(pv);
        assign lo_b = 18'(sp) - 18'(thr_reg[g]);
        assign hi_b = 18'(sp) + 18'(thr_reg[g]);

        always_comb begin
            case (func_reg[g])
                PAU_FN_SENSOR:   cond = pins_reg.signal_lost || pins_reg.out_of_range ||
                                        pins_reg.rtd_short;
                PAU_FN_EVENT:    cond = PROGRAM_I.running &&
                                        PROGRAM_I.segment == seg_reg[g];
                PAU_FN_ABS_MIN:  cond = pv < thr_reg[g];
                PAU_FN_ABS_MAX:  cond = pv > thr_reg[g];
                PAU_FN_DEV_LOW:  cond = pv_x < lo_b;
                PAU_FN_DEV_HIGH: cond = pv_x > hi_b;
                PAU_FN_DEV_BAND: cond = thr_reg[g][15] ?
                                        (pv_x >= hi_b && pv_x <= lo_b) :
                                        (pv_x < lo_b || pv_x > hi_b);
                default:         cond = 1'b0;
            endcase
        end

        // The block flag is set by power-up and dropped by the first clear
        // condition of a configured function, so apart from the sensor function only a later recurrence is
        // recognised; a function still off after reset must not drop it.
        always_ff @(posedge CLK_I) begin
            if (RESET_I) begin
                blocked_reg <= 1'b1;
            end else if (!cond && func_reg[g] != PAU_FN_OFF) begin
                blocked_reg <= 1'b0;
            end
        end

        assign rec = cond && !(ctrl_reg[`PAU_CTRL_BLK_LSB + g] && blocked_reg &&
                               func_reg[g] != PAU_FN_SENSOR);
        assign last = sec_tick && cnt_reg <= 13'h0001;

        always_ff @(posedge CLK_I) begin
            if (RESET_I || !rec) begin
                st_reg  <= PAU_T_IDLE;
                cnt_reg <= '0;
            end else begin
                if (sec_tick && cnt_reg != '0) begin
                    cnt_reg <= cnt_reg - 13'h1;
                end
                case (st_reg)
                    PAU_T_IDLE: begin
                        if (t1_reg[g] != '0) begin
                            st_reg  <= PAU_T_PULSE;
                            cnt_reg <= t1_reg[g];
                        end else if (t2_reg[g] != '0) begin
                            st_reg  <= PAU_T_DELAY;
                            cnt_reg <= t2_reg[g];
                        end else begin
                            st_reg <= PAU_T_ON;
                        end
                    end
                    PAU_T_PULSE: begin
                        if (last) begin
                            st_reg  <= (t2_reg[g] == '0) ? PAU_T_DONE : PAU_T_GAP;
                            cnt_reg <= t2_reg[g];
                        end
                    end
                    PAU_T_GAP: begin
                        if (last) begin
                            st_reg  <= PAU_T_PULSE;
                            cnt_reg <= t1_reg[g];
                        end
                    end
                    PAU_T_DELAY: begin
                        if (last) begin
                            st_reg <= PAU_T_ON;
                        end
                    end
                    PAU_T_ON: begin
                    end
                    PAU_T_DONE: begin
                    end
                    default: begin
                        st_reg <= PAU_T_IDLE;
                    end
                endcase
            end
        end

        assign led[g]  = rec;
        assign aout[g] = rec && (st_reg == PAU_T_ON || st_reg == PAU_T_PULSE);
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ALARM_OUT_O <= '0;
            ALARM_LED_O <= '0;
        end else begin
            ALARM_OUT_O <= aout;
            ALARM_LED_O <= led;
        end
    end

    // =====================================================================
    // Control output: ownership, on/off and soft-start ramp
    // =====================================================================
    logic [TW-1:0] elapsed_reg;
    logic [9:0]    lim_reg;
    logic [9:0]    demand;
    logic [9:0]    limited;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            elapsed_reg <= '0;
        end else if (sec_tick && elapsed_reg != {TW{1'b1}}) begin
            elapsed_reg <= elapsed_reg + 13'h1;
        end
    end

    // The ramp climbs one step per cycle while step times the soft-start
    // time stays within elapsed seconds at full scale, avoiding a divider.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            lim_reg <= '0;
        end else if (lim_reg < `PAU_FULL_OUT &&
                     24'(24'(lim_reg + 10'h1) * soft_reg) <=
                     24'(elapsed_reg * `PAU_FULL_OUT)) begin
            lim_reg <= lim_reg + 10'h1;
        end
    end

    always_comb begin
        if (!ctrl_reg[`PAU_CTRL_AUTO]) begin
            demand = mv_reg;
        end else if (pb_reg == '0) begin
            demand = (pv < sp) ? `PAU_FULL_OUT : 10'h000;
        end else begin
            demand = PID_I;
        end
        if (soft_reg == '0 || demand <= lim_reg) begin
            limited = demand;
        end else begin
            limited = lim_reg;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            CTRL_OUT_O <= '0;
        end else begin
            CTRL_OUT_O <= limited;
        end
    end

    // =====================================================================
    // Retransmission: linear scaling to a 12-bit code, one bit per cycle
    // =====================================================================
    logic signed [16:0] rtx_x;
    logic signed [16:0] rtx_span;
    logic [27:0]        num_reg;
    logic [15:0]        den_reg;
    logic [11:0]        q_reg;
    logic [3:0]         dv_idx_reg;
    logic [11:0]        q_try;
    logic [15:0]        rtx_off;

    assign rtx_x    = 17'(ctrl_reg[`PAU_CTRL_RTX_SP] ? sp : pv) - 17'(rtx_lo_reg);
    assign rtx_span = 17'(rtx_hi_reg) - 17'(rtx_lo_reg);
    assign rtx_off  = (rtx_x < 0) ? 16'h0000 : (rtx_x > rtx_span) ? rtx_span[15:0] : rtx_x[15:0];
    assign q_try    = q_reg | (12'h001 << dv_idx_reg);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            num_reg    <= '0;
            den_reg    <= '0;
            q_reg      <= '0;
            dv_idx_reg <= 4'hB;
            RETX_O     <= '0;
        end else if (dv_idx_reg == 4'hF) begin
            RETX_O     <= (den_reg == '0) ? 12'h000 : q_reg;
            q_reg      <= '0;
            num_reg    <= 28'(rtx_off * `PAU_DAC_FULL);
            den_reg    <= (rtx_span <= 0) ? 16'h0000 : rtx_span[15:0];
            dv_idx_reg <= 4'hB;
        end else begin
            if (28'(q_try * den_reg) <= num_reg) begin
                q_reg <= q_try;
            end
            dv_idx_reg <= dv_idx_reg - 4'h1;
        end
    end

    // =====================================================================
    // Read port
    // =====================================================================
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        case (ADDR_I)
            `PAU_A_CTRL:    rd_mux = ctrl_reg;
            `PAU_A_MV:      rd_mux = {6'h00, mv_reg};
            `PAU_A_PB:      rd_mux = pb_reg;
            `PAU_A_SOFT:    rd_mux = {3'h0, soft_reg};
            `PAU_A_RTX_LO:  rd_mux = rtx_lo_reg;
            `PAU_A_RTX_HI:  rd_mux = rtx_hi_reg;
            `PAU_A_STATUS:  rd_mux = {8'h00, ALARM_OUT_O, ALARM_LED_O};
            `PAU_A_OUTPCT:  rd_mux = {6'h00, CTRL_OUT_O};
            `PAU_A_MAIN_SP: rd_mux = main_sp_reg;
            `PAU_A_PV:      rd_mux = pv;
            default: begin
                for (int n = 0; n < NA; n++) begin
                    if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE)) begin
                        rd_mux = {2'h0, seg_reg[n], 5'h00, func_reg[n]};
                    end
                    if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_THR)) begin
                        rd_mux = thr_reg[n];
                    end
                    if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_T1)) begin
                        rd_mux = {3'h0, t1_reg[n]};
                    end
                    if (ADDR_I == 8'(`PAU_A_ALM_BASE + n * `PAU_A_ALM_STRIDE + `PAU_A_ALM_T2)) begin
                        rd_mux = {3'h0, t2_reg[n]};
                    end
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || !RD_I) begin
            RDATA_O <= '0;
        end else begin
            RDATA_O <= rd_mux;
        end
    end

endmodule

// *** shared/pau_consts.svh ***
/*
 * Constants of the process alarm unit: register offsets, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PAU_CONSTS_SVH
`define PAU_CONSTS_SVH


`define PAU_A_CTRL        8'h00
`define PAU_A_MV          8'h04
`define PAU_A_PB          8'h08
`define PAU_A_SOFT        8'h0C
`define PAU_A_RTX_LO      8'h10
`define PAU_A_RTX_HI      8'h14
`define PAU_A_STATUS      8'h18
`define PAU_A_OUTPCT      8'h1C
`define PAU_A_MAIN_SP     8'h20
`define PAU_A_PV          8'h24
`define PAU_A_ALM_BASE    8'h40
`define PAU_A_ALM_STRIDE  8'h10
`define PAU_A_ALM_FUNC    8'h00
`define PAU_A_ALM_THR     8'h04
`define PAU_A_ALM_T1      8'h08
`define PAU_A_ALM_T2      8'h0C

`define PAU_CTRL_AUTO     0
`define PAU_CTRL_RSP_EN   1
`define PAU_CTRL_SQRT     2
`define PAU_CTRL_RTX_SP   3
`define PAU_CTRL_BLK_LSB  4
`define PAU_CTRL_RESET    16'h0001

`define PAU_FULL_OUT      10'h3E8
`define PAU_CUR_ZERO      16'h0FA0
`define PAU_CUR_SPAN      16'h3E80
`define PAU_DAC_FULL      12'hFFF
`define PAU_SEC_NS        1000000000
`define PAU_CLK_NS        5
`define PAU_SEC_CYCLES    (`PAU_SEC_NS / `PAU_CLK_NS)
`define PAU_TIME_W        13
`define PAU_NUM_ALARMS    4

`endif

// *** shared/pau_pkg.sv ***
/*
 * Types of the process alarm unit: alarm functions, timer states and carriers.
 * Assumes pau_consts.svh is on the include path.
 */
`include "pau_consts.svh"

package pau_pkg;

    typedef enum logic [2:0] {
        PAU_FN_OFF      = 3'h0,
        PAU_FN_SENSOR   = 3'h1,
        PAU_FN_EVENT    = 3'h2,
        PAU_FN_ABS_MIN  = 3'h3,
        PAU_FN_ABS_MAX  = 3'h4,
        PAU_FN_DEV_LOW  = 3'h5,
        PAU_FN_DEV_HIGH = 3'h6,
        PAU_FN_DEV_BAND = 3'h7
    } pau_func_e;

    typedef enum logic [2:0] {
        PAU_T_IDLE  = 3'h0,
        PAU_T_ON    = 3'h1,
        PAU_T_PULSE = 3'h2,
        PAU_T_GAP   = 3'h3,
        PAU_T_DELAY = 3'h4,
        PAU_T_DONE  = 3'h5
    } pau_tstate_e;

    typedef struct packed {
        logic remote_select;
        logic rtd_short;
        logic out_of_range;
        logic signal_lost;
    } pau_pins_s;

    typedef struct packed {
        logic       running;
        logic [5:0] segment;
    } pau_program_s;

endpackage

// *** tb/pau_top_props.sv ***
/* Port checker of the process alarm unit.
   Assumes bind onto pau_top and the register map of pau_consts.svh. */
`timescale 1ns/1ps
module pau_top_props (
    input wire logic                  CLK_I,
    input wire logic                  RESET_I,
    input wire logic [7:0]            ADDR_I,
    input wire logic                  RD_I,
    input wire logic [15:0]           RDATA_O,
    input wire pau_pkg::pau_pins_s    PINS_I,
    input wire logic signed [15:0]    REMOTE_SP_I,
    input wire logic [3:0]            ALARM_OUT_O,
    input wire logic [3:0]            ALARM_LED_O,
    input wire logic [9:0]            CTRL_OUT_O,
    input wire logic signed [15:0]    SETPOINT_O,
    input wire logic [11:0]           RETX_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // ====================
    // Checks.
    reset_clear_a: assert property (disable iff (1'b0) RESET_I |=> ALARM_OUT_O == 4'h0
        && ALARM_LED_O == 4'h0 && CTRL_OUT_O == 10'h000 && RDATA_O == 16'h0000)
        else $error("outputs not cleared by reset");
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (RD_I && ADDR_I == 8'hFC |=> RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    status_read_a: assert property (RD_I && ADDR_I == 8'h18 |=>
        RDATA_O == {8'h00, $past(ALARM_OUT_O), $past(ALARM_LED_O)})
        else $error("status read wrong");
    out_needs_lamp_a: assert property ((ALARM_OUT_O & ~$past(ALARM_LED_O)) == 4'h0)
        else $error("alarm output without lamp");
    ctrl_limit_a: assert property (CTRL_OUT_O <= 10'h3E8)
        else $error("control output above full");
    remote_sp_a: assert property ((PINS_I.remote_select && $stable(REMOTE_SP_I))[*8]
        |-> SETPOINT_O == REMOTE_SP_I) else $error("remote setpoint not taken");
    retx_hold_a: assert property ($changed(RETX_O) |=> $stable(RETX_O)[*8])
        else $error("retransmission refreshed too often");
endmodule
bind pau_top pau_top_props u_pau_top_props (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PINS_I(PINS_I),
    .REMOTE_SP_I(REMOTE_SP_I), .ALARM_OUT_O(ALARM_OUT_O), .ALARM_LED_O(ALARM_LED_O),
    .CTRL_OUT_O(CTRL_OUT_O), .SETPOINT_O(SETPOINT_O), .RETX_O(RETX_O));

// *** tb/pau_sensor_model.sv ***
/* Sensor front end and contact model feeding the alarm unit.
   Assumes one clock shared with the unit. */
`timescale 1ns/1ps
module pau_sensor_model (
    input  wire logic               clk_i,
    input  wire logic signed [15:0] pv_i,
    input  wire logic               brk_i,
    input  wire logic               rsel_i,
    output logic signed [15:0]      pv_o = 16'h0000,
    output pau_pkg::pau_pins_s      pins_o = '0,
    output logic [15:0]             cur_o = 16'h0FA0
);
    // ====================
    // Front end.
    // The contacts are registered so they change only on the rising edge of the shared clock.
    always @(posedge clk_i) begin
        pv_o   <= pv_i;
        pins_o <= {rsel_i, 1'b0, 1'b0, brk_i};
        cur_o  <= 16'h0FA0 + {8'h00, pv_i[7:0]};
    end
endmodule

// *** tb/test_process_alarm_unit.sv ***
/* Self-checking bench of the process alarm unit.
   Assumes pau_top, the sensor model and the bound checker. */
`timescale 1ns/1ps
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t %h %h", $time, (a), (b)); end end
module test_process_alarm_unit;
    import pau_pkg::*;
    logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, brk = 0, rsel = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, d, cur;
    logic signed [15:0] pv_cmd = 16'h0000, pv, sp;
    pau_pins_s pins;
    pau_program_s prog = '0;
    logic [3:0] aout, led;
    logic [9:0] ctrl;
    logic [11:0] retx;
    int err_total = 0, comparisons = 0, n;
    always #2.5 clk = ~clk;
    pau_sensor_model u_pau_sensor_model (.clk_i(clk), .pv_i(pv_cmd), .brk_i(brk),
        .rsel_i(rsel), .pv_o(pv), .pins_o(pins), .cur_o(cur));
    // A one-second tick of 20 cycles keeps the timed alarms short.
    pau_top #(.SEC_CYCLES(20)) u_pau_top (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .PINS_I(pins),
        .PROGRAM_I(prog), .PV_I(pv), .CURRENT_I(cur), .REMOTE_SP_I(16'h0123),
        .PID_I(10'h0C8), .ALARM_OUT_O(aout), .ALARM_LED_O(led), .CTRL_OUT_O(ctrl),
        .SETPOINT_O(sp), .RETX_O(retx));
    // ====================
    // Tasks.
    task test_done;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    function logic [15:0] pr(input int s);
        case (s)
            0: pr = {12'h000, led};
            1: pr = {6'h00, ctrl};
            2: pr = sp;
            default: pr = {4'h0, retx};
        endcase
    endfunction
    // Bounded wait on a probe; a miss ends the run.
    task wt(input int s, input logic [15:0] v);
        n = 0;
        do begin @(posedge clk); #1 n++; end while (pr(s) !== v && n < 200);
        `chk(pr(s), v)
        if (n >= 200) test_done;
    endtask
    // ====================
    // Sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wr(8'h04, 16'h01F4); rd(8'h04, d); `chk(d, 16'h01F4)
        rd(8'hFC, d); rd(8'h18, d);
        wr(8'h10, 16'h0000); wr(8'h14, 16'h03E8);
        wr(8'h40, 16'h0004); wr(8'h44, 16'h0064); wr(8'h50, 16'h0003);
        wr(8'h54, 16'hFFCE); wr(8'h60, 16'h0001); wr(8'h70, 16'h0004);
        wr(8'h74, 16'h0064); wr(8'h7C, 16'h0002);
        pv_cmd <= 16'sd200;
        wt(0, 16'h0009); `chk(aout[3], 1'b0)
        n = 0;
        while (aout !== 4'h9 && n < 100) begin @(posedge clk); #1 n++; end
        `chk(n >= 20 && n <= 45, 1'b1)
        if (n >= 100) test_done;
        pv_cmd <= -16'sd100;
        wt(0, 16'h0002); @(posedge clk); #1 `chk(aout, 4'h2)
        brk <= 1'b1; wt(0, 16'h0006);
        brk <= 1'b0; pv_cmd <= 16'sd0; wt(0, 16'h0000);
        wr(8'h20, 16'h01F4); wr(8'h08, 16'h0000); wr(8'h0C, 16'h0000);
        wt(1, 16'h03E8);
        pv_cmd <= 16'sd600; wt(1, 16'h0000);
        wt(3, 16'h0999);
        wr(8'h00, 16'h0000); wt(1, 16'h01F4);
        rsel <= 1'b1; wt(2, 16'h0123);
        // A second reset restarts the soft-start ramp and the initial blocking.
        @(posedge clk) rst <= 1'b1;
        rsel <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wr(8'h00, 16'h0051); wr(8'h0C, 16'h0064); wr(8'h20, 16'h03E8);
        wr(8'h44, 16'h0064); wr(8'h40, 16'h0004); brk <= 1'b1; wr(8'h60, 16'h0001);
        wt(0, 16'h0004);
        rd(8'h1C, d); `chk(d <= 16'h0014, 1'b1)
        wr(8'h0C, 16'h0000); wt(1, 16'h03E8);
        pv_cmd <= 16'sd0; repeat (4) @(posedge clk);
        pv_cmd <= 16'sd600; wt(0, 16'h0005);
        @(posedge clk); #1 `chk(aout, 4'h5)
        wr(8'h70, 16'h0502); prog <= 7'h45; wt(0, 16'h000D);
        prog <= 7'h46; wt(0, 16'h0005);
        wr(8'h54, 16'hFE70); wr(8'h50, 16'h0007); wt(0, 16'h0007);
        pv_cmd <= 16'sd0; wt(0, 16'h0004);
        wr(8'h54, 16'h0190); wt(0, 16'h0006);
        pv_cmd <= 16'sd10; wr(8'h00, 16'h0055); repeat (40) @(posedge clk);
        rd(8'h24, d); `chk(d, 16'h0190)
        test_done;
    end
endmodule
